/* logic/adco_map.svh */
// Constants for the converter output sequencing block
`ifndef ADCO_MAP_SVH
`define ADCO_MAP_SVH

`define ADCO_SAMPLE_WIDTH     12
`define ADCO_LAT_STAGES       17
`define ADCO_SETTLE_CYC       1000
`define ADCO_FIFO_DEPTH       8
`define ADCO_CLK_PERIOD_PS    25000
`define ADCO_STOP_TIME_NS     1000
`define ADCO_STOP_CYC         ((`ADCO_STOP_TIME_NS * 1000 + `ADCO_CLK_PERIOD_PS - 1) / `ADCO_CLK_PERIOD_PS)

`endif

/* logic/adco_pkg.sv */
// Types for the converter output sequencing block
`default_nettype none
package adco_pkg;
    typedef enum logic [1:0] {
        ADCO_ST_OFF    = 2'b00,
        ADCO_ST_SETTLE = 2'b01,
        ADCO_ST_RUN    = 2'b10
    } adco_state_t;
endpackage
`default_nettype wire

/* logic/adco_fifo.sv */
// Sample FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module adco_fifo #(
    parameter int W = 12,
    parameter int D = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         ce,
    // Fill side
    input  wire logic         wr_valid,
    output logic              wr_ready,
    input  wire logic [W-1:0] wr_data,
    // Drain side
    output logic              rd_valid,
    input  wire logic         rd_ready,
    output logic [W-1:0]      rd_data
);
    localparam int AW = $clog2(D);

    initial begin
        if (D < 2 || (1 << AW) != D || W < 1) begin
            $error("adco_fifo: depth must be a power of two of at least 2");
        end
    end

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;

    wire do_wr = wr_valid && wr_ready;
    wire do_rd = (cnt_r != '0) && (!rd_valid || rd_ready);

    assign wr_ready = (cnt_r != (AW+1)'(D));

    always_ff @(posedge clk) begin
        if (ce && do_wr) begin
            mem[wp_r] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wp_r     <= '0;
            rp_r     <= '0;
            cnt_r    <= '0;
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end else if (ce) begin
            if (do_wr) begin
                wp_r <= wp_r + AW'(1);
            end
            if (do_rd) begin
                rd_data  <= mem[rp_r];
                rp_r     <= rp_r + AW'(1);
                rd_valid <= 1'b1;
            end else if (rd_ready) begin
                rd_valid <= 1'b0;
            end
            cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule // adco_fifo
`default_nettype wire

/* logic/adco_core.sv */
// Converter output pipeline, wake-up and output-enable sequencing
//
// Overview of operation
// - A sample appears on the data outputs 17.5 sample-clock cycles after capture.
// - Outputs drive within one cycle of enable; timing stable after 1000 cycles.
// - Valid data no later than 1000 sample cycles after leaving power-down.
// - After the sample clock stops and restarts, valid data within 1000 cycles.
// - Falling-edge output clock polarity moves the data window half a period later.
`timescale 1ns/1ps
`default_nettype none
`include "adco_map.svh"
module adco_core #(
    parameter int W        = `ADCO_SAMPLE_WIDTH,
    parameter int LAT      = `ADCO_LAT_STAGES,
    parameter int SETTLE   = `ADCO_SETTLE_CYC,
    parameter int FD       = `ADCO_FIFO_DEPTH,
    parameter int STOP_CYC = `ADCO_STOP_CYC
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         ce,
    // Pins from outside
    input  wire logic         sample_clk,
    input  wire logic [W-1:0] sample_word,
    input  wire logic         out_enable,
    input  wire logic         power_down,
    input  wire logic         output_sample_clock_falling,
    // Parallel output pins
    output logic [W-1:0]      data_out,
    output logic              data_oe,
    output logic              output_sample_clock,
    output logic              data_valid,
    output logic              timing_stable,
    // Buffered sample stream
    output logic [W-1:0]      tap_data,
    output logic              tap_valid,
    input  wire logic         tap_ready,
    output logic              tap_overflow
);
    initial begin
        // Valid data must not be flagged while the delay line still holds stale words
        if (LAT < 1 || SETTLE <= LAT || SETTLE > 65535) begin
            $error("adco_core: settling count must exceed the pipeline depth");
        end
        if (STOP_CYC < 1 || STOP_CYC > 65535) begin
            $error("adco_core: parameter out of range");
        end
    end

    function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic [15:0] lim);
        sat_inc = (v >= lim) ? lim : v + 16'h0001;
    endfunction

    localparam logic [15:0] SETTLE_L = 16'(SETTLE);
    localparam logic [15:0] STOP_L   = 16'(STOP_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [3:0]   pin_s1_r;
    logic [3:0]   pin_s2_r;
    logic [W-1:0] word_s1_r;
    logic [W-1:0] word_s2_r;
    logic         sclk_prev_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_s1_r    <= 4'h0;
            pin_s2_r    <= 4'h0;
            word_s1_r   <= '0;
            word_s2_r   <= '0;
            sclk_prev_r <= 1'b0;
        end else if (ce) begin
            pin_s1_r    <= {output_sample_clock_falling, power_down, out_enable, sample_clk};
            pin_s2_r    <= pin_s1_r;
            word_s1_r   <= sample_word;
            word_s2_r   <= word_s1_r;
            sclk_prev_r <= pin_s2_r[0];
        end
    end

    wire sclk_s    = pin_s2_r[0];
    wire oe_s      = pin_s2_r[1];
    wire pd_s      = pin_s2_r[2];
    wire pol_s     = pin_s2_r[3];
    wire rise_tick = sclk_s && !sclk_prev_r;
    wire fall_tick = !sclk_s && sclk_prev_r;
    wire upd_tick  = pol_s ? rise_tick : fall_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Sample delay line, one stage per sample-clock rising edge
    logic [W-1:0] dly_r [LAT+1];

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i <= LAT; i++) begin
                dly_r[i] <= '0;
            end
        end else if (ce && rise_tick) begin
            dly_r[0] <= word_s2_r;
            for (int i = 1; i <= LAT; i++) begin
                dly_r[i] <= dly_r[i-1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake-up sequencing
    adco_pkg::adco_state_t st_r;
    adco_pkg::adco_state_t st_nxt;
    logic [15:0] settle_r;
    logic [15:0] idle_r;
    logic [15:0] stable_r;

    wire stopped   = (idle_r == STOP_L);
    wire settle_ok = rise_tick && (settle_r == SETTLE_L - 16'h0001);

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            adco_pkg::ADCO_ST_OFF:    if (!pd_s) st_nxt = adco_pkg::ADCO_ST_SETTLE;
            adco_pkg::ADCO_ST_SETTLE: if (settle_ok && !stopped) st_nxt = adco_pkg::ADCO_ST_RUN;
            adco_pkg::ADCO_ST_RUN:    if (stopped) st_nxt = adco_pkg::ADCO_ST_SETTLE;
            default:                  st_nxt = adco_pkg::ADCO_ST_OFF;
        endcase
        if (pd_s) begin
            st_nxt = adco_pkg::ADCO_ST_OFF;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r     <= adco_pkg::ADCO_ST_OFF;
            settle_r <= 16'h0000;
            idle_r   <= 16'h0000;
            stable_r <= 16'h0000;
        end else if (ce) begin
            st_r   <= st_nxt;
            idle_r <= (rise_tick || fall_tick) ? 16'h0000 : sat_inc(idle_r, STOP_L);
            // Settling count restarts while powered down or while the clock is stopped
            if (st_r != adco_pkg::ADCO_ST_SETTLE || stopped) begin
                settle_r <= 16'h0000;
            end else if (rise_tick) begin
                settle_r <= sat_inc(settle_r, SETTLE_L);
            end
            if (!oe_s || st_r != adco_pkg::ADCO_ST_RUN) begin
                stable_r <= 16'h0000;
            end else if (rise_tick) begin
                stable_r <= sat_inc(stable_r, SETTLE_L);
            end
        end
    end

    wire run_nxt = (st_nxt == adco_pkg::ADCO_ST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Output pins
    always_ff @(posedge clk) begin
        if (reset) begin
            data_out            <= '0;
            data_oe             <= 1'b0;
            output_sample_clock <= 1'b0;
            data_valid          <= 1'b0;
            timing_stable       <= 1'b0;
        end else if (ce) begin
            if (!run_nxt) begin
                data_out <= '0;
            end else if (upd_tick) begin
                data_out <= dly_r[LAT];
            end
            data_oe             <= oe_s;
            output_sample_clock <= sclk_s && !pd_s;
            data_valid          <= run_nxt;
            timing_stable       <= run_nxt && oe_s && (stable_r == SETTLE_L);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Buffered stream of valid samples; overflow when the drain side stalls
    logic fill_ready;
    wire  push = ce && upd_tick && run_nxt && oe_s;

    adco_fifo #(
        .W (W),
        .D (FD)
    ) u_fifo (
        .clk      (clk),
        .reset    (reset),
        .ce       (ce),
        .wr_valid (push),
        .wr_ready (fill_ready),
        .wr_data  (dly_r[LAT]),
        .rd_valid (tap_valid),
        .rd_ready (tap_ready),
        .rd_data  (tap_data)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            tap_overflow <= 1'b0;
        end else if (ce && push && !fill_ready) begin
            tap_overflow <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_oe_rise;
        ce && $rose(oe_s);
    endsequence

    sequence s_out_update;
        ce && upd_tick && run_nxt;
    endsequence

    a_data_latency: assert property (@(posedge clk) disable iff (reset)
        s_out_update |=> data_out == $past(dly_r[LAT]))
        else $error("output word not taken from last delay stage");

    a_oe_drive: assert property (@(posedge clk) disable iff (reset)
        s_oe_rise |=> data_oe)
        else $error("data not driven after output enable");

    a_stable_gate: assert property (@(posedge clk) disable iff (reset)
        timing_stable |-> data_valid && data_oe && $past(stable_r) == SETTLE_L)
        else $error("timing stable flagged too early");

    a_wake_bound: assert property (@(posedge clk) disable iff (reset)
        st_r == adco_pkg::ADCO_ST_SETTLE |-> settle_r < SETTLE_L)
        else $error("settling count passed its bound");

    a_wake_done: assert property (@(posedge clk) disable iff (reset)
        ce && st_r == adco_pkg::ADCO_ST_SETTLE && settle_ok && !stopped && !pd_s
        |=> data_valid && st_r == adco_pkg::ADCO_ST_RUN)
        else $error("valid data not flagged at end of settling");

    a_clock_stop: assert property (@(posedge clk) disable iff (reset)
        ce && stopped |=> !data_valid && settle_r == 16'h0000)
        else $error("stopped clock not forcing resettle");

    a_polarity_edge: assert property (@(posedge clk) disable iff (reset)
        $changed(data_out) |-> $past(upd_tick) || !data_valid)
        else $error("data changed away from its polarity edge");
endmodule // adco_core
`default_nettype wire

/* tb/adco_src.sv */
// Converter-side source and configuration controller model
`timescale 1ns/1ps
`default_nettype none
module adco_src (
    // Control
    input  wire logic   run,
    input  wire logic   reset,
    // Pins
    output logic        sample_clk,
    output logic [11:0] sample_word,
    output logic [11:0] cnt,
    // Configuration port
    output logic        serial_load_enable_n
);
    // Supplies count as up for over 10 ms before time zero, so reset may pulse at once
    // Load enable idles high and drops only 2 us after each reset release
    initial begin
        serial_load_enable_n = 1'b1;
        forever begin
            @(negedge reset);
            #2000;
            serial_load_enable_n = 1'b0;
            #3200;
            serial_load_enable_n = 1'b1;
        end
    end

    // Clock stands low while stopped; word n rides on rise n
    initial begin
        sample_clk = 1'b0;
        cnt = 12'h000;
        sample_word = 12'h000;
        #3;
        forever begin
            if (run) begin
                sample_clk = 1'b1;
                #100;
                sample_clk = 1'b0;
                cnt = cnt + 12'h001;
                sample_word = cnt;
            end
            #100;
        end
    end
endmodule // adco_src
`default_nettype wire

/* tb/adc_output_reset_sequencing_tb.sv */
// Self-checking bench for the converter output sequencing block
`timescale 1ns/1ps
`default_nettype none
module adc_output_reset_sequencing_tb;
    localparam int ST = 20;
    logic clk = 0, reset = 1, ce = 1, out_enable = 0, power_down = 1;
    logic output_sample_clock_falling = 0, tap_ready = 0, run = 1;
    logic sample_clk, data_oe, output_sample_clock, data_valid;
    logic timing_stable, tap_valid, tap_overflow, serial_load_enable_n;
    logic [11:0] sample_word, cnt, data_out, tap_data;
    int miscompares = 0, total_checks = 0, cyc = 0;

    always #12.5 clk = ~clk;

    adco_src src (
        .run(run), .reset(reset), .sample_clk(sample_clk), .sample_word(sample_word),
        .cnt(cnt), .serial_load_enable_n(serial_load_enable_n)
    );

    adco_core #(.SETTLE(ST)) DUT (
        .clk(clk), .reset(reset), .ce(ce), .sample_clk(sample_clk),
        .sample_word(sample_word), .out_enable(out_enable), .power_down(power_down),
        .output_sample_clock_falling(output_sample_clock_falling), .data_out(data_out), .data_oe(data_oe),
        .output_sample_clock(output_sample_clock), .data_valid(data_valid),
        .timing_stable(timing_stable), .tap_data(tap_data), .tap_valid(tap_valid),
        .tap_ready(tap_ready), .tap_overflow(tap_overflow)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_w(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic got, input logic exp);
        chk_w({11'h000, got}, {11'h000, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_wake;
        int n = 0;
        power_down <= 1'b0;
        chk_w(data_out, 12'h000);
        while (data_valid !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk_b(n >= (ST - 1) * 8 && n <= (ST + 2) * 8, 1'b1);
        $display("test wake done");
    endtask

    task automatic t_lat(input logic pol);
        logic [11:0] prev;
        @(posedge clk);
        output_sample_clock_falling <= pol;
        repeat (24) @(posedge clk);
        repeat (4) begin
            prev = data_out;
            for (int i = 0; i < 12; i++) begin
                @(posedge clk);
                #1;
                if (data_out !== prev) break;
            end
            chk_w(data_out, cnt - 12'h012);
            chk_b(sample_clk, pol);
            chk_b(output_sample_clock, pol);
        end
        $display("test latency done");
    endtask

    task automatic t_oe;
        int n = 0;
        chk_b(data_oe, 1'b0);
        out_enable <= 1'b1;
        while (data_oe !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk_b(n <= 8, 1'b1);
        chk_b(timing_stable, 1'b0);
        n = 0;
        while (timing_stable !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk_b(n >= (ST - 1) * 8 && n <= (ST + 2) * 8, 1'b1);
        $display("test output enable done");
    endtask

    task automatic t_tap;
        logic [11:0] w0;
        int n = 0;
        while (tap_overflow !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk_b(tap_overflow, 1'b1);
        tap_ready <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (tap_valid !== 1'b1 && n < 20);
            if (i == 0) w0 = tap_data;
            chk_w(tap_data, w0 + 12'(i));
        end
        @(posedge clk);
        tap_ready <= 1'b0;
        $display("test buffer done");
    endtask

    task automatic t_stop;
        int n = 0;
        run = 1'b0;
        while (data_valid !== 1'b0 && n < 80) begin
            @(posedge clk);
            n++;
        end
        chk_b(n >= 36 && n <= 56, 1'b1);
        chk_w(data_out, 12'h000);
        run = 1'b1;
        n = 0;
        while (data_valid !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk_b(n <= (ST + 2) * 8, 1'b1);
        $display("test clock stop done");
    endtask

    task automatic t_pd;
        power_down <= 1'b1;
        repeat (8) @(posedge clk);
        chk_b(data_valid, 1'b0);
        chk_b(output_sample_clock, 1'b0);
        chk_w(data_out, 12'h000);
        $display("test power down done");
    endtask

    task automatic t_ce;
        logic [11:0] held;
        @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        held = data_out;
        repeat (20) @(posedge clk);
        chk_w(data_out, held);
        chk_b(data_valid, 1'b1);
        ce <= 1'b1;
        $display("test clock enable done");
    endtask

    task automatic t_reset;
        reset <= 1'b1;
        repeat (80) @(posedge clk);
        chk_b(data_valid, 1'b0);
        chk_b(tap_overflow, 1'b0);
        chk_w(data_out, 12'h000);
        reset <= 1'b0;
        @(posedge clk);
        chk_b(data_oe, 1'b0);
        chk_b(timing_stable, 1'b0);
        chk_b(serial_load_enable_n, 1'b1);
        $display("test mid-run reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk_b(data_valid, 1'b0);
        t_wake();
        t_lat(1'b0);
        t_lat(1'b1);
        t_ce();
        t_oe();
        t_tap();
        t_stop();
        t_pd();
        t_reset();
        final_report();
    end
endmodule // adc_output_reset_sequencing_tb
`default_nettype wire
